// *** timer_pkg.sv ***
package timer_pkg;

	// register addresses
	localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h88;
	localparam logic [7:0] ADDR_MODE_CONFIG = 8'h89;
	localparam logic [7:0] ADDR_ZERO_LOW = 8'h8a;
	localparam logic [7:0] ADDR_ONE_LOW = 8'h8b;
	localparam logic [7:0] ADDR_ZERO_HIGH = 8'h8c;
	localparam logic [7:0] ADDR_ONE_HIGH = 8'h8d;

	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] UNMAPPED_BYTE = 8'h00;
	localparam logic [7:0] ALL_ONES_BYTE = 8'hff;
	localparam logic [12:0] ALL_ONES_13 = 13'h1fff;
	localparam logic [15:0] ALL_ONES_16 = 16'hffff;

	// control and status bit positions
	localparam int BIT_ONE_OVF = 7;
	localparam int BIT_ONE_RUN = 6;
	localparam int BIT_ZERO_OVF = 5;
	localparam int BIT_ZERO_RUN = 4;
	localparam int BIT_IRQ_ONE_FLAG = 3;
	localparam int BIT_IRQ_ONE_TYPE = 2;
	localparam int BIT_IRQ_ZERO_FLAG = 1;
	localparam int BIT_IRQ_ZERO_TYPE = 0;

	// mode register bit positions
	localparam int BIT_ONE_GATING = 7;
	localparam int BIT_ONE_COUNT_SEL = 6;
	localparam int BIT_ONE_MODE_HI = 5;
	localparam int BIT_ONE_MODE_LO = 4;
	localparam int BIT_ZERO_GATING = 3;
	localparam int BIT_ZERO_COUNT_SEL = 2;
	localparam int BIT_ZERO_MODE_HI = 1;
	localparam int BIT_ZERO_MODE_LO = 0;

	// pin vector positions for the synchroniser
	localparam int PIN_COUNT_ZERO = 0;
	localparam int PIN_COUNT_ONE = 1;
	localparam int PIN_IRQ_ZERO = 2;
	localparam int PIN_IRQ_ONE = 3;
	localparam int PIN_TOTAL = 4;

	typedef enum logic [1:0] {
		MODE_13BIT = 2'b00,
		MODE_16BIT = 2'b01,
		MODE_RELOAD = 2'b10,
		MODE_SPLIT = 2'b11
	} timer_mode_t;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic bit_wr_en;
		logic [2:0] bit_sel;
		logic bit_val;
	} sfr_req_t;

	typedef struct packed {
		logic timer_one;
		logic timer_zero;
		logic ext_irq_one;
		logic ext_irq_zero;
	} vector_ack_t;

endpackage

// *** pin_sync.sv ***
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// raw pins
	input wire logic [WIDTH-1:0] pin_in,
	// synchronised level and its previous sample
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] level_prev
);
	logic [WIDTH-1:0] stage_one_reg;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_pin
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					stage_one_reg[i] <= 1'b0;
					level[i] <= 1'b0;
					level_prev[i] <= 1'b0;
				end else begin
					stage_one_reg[i] <= pin_in[i];
					level[i] <= stage_one_reg[i];
					level_prev[i] <= level[i];
				end
			end
		end
	endgenerate
endmodule

// *** count_unit.sv ***
`timescale 1ns/100ps
module count_unit (
	// configuration and step
	input timer_pkg::timer_mode_t mode,
	input wire logic tick,
	// present count
	input wire logic [7:0] low,
	input wire logic [7:0] high,
	// next count and overflow
	output logic [7:0] low_next,
	output logic [7:0] high_next,
	output logic overflow
);
	import timer_pkg::*;

	wire [12:0] count_13 = {high, low[4:0]};
	wire [12:0] inc_13 = count_13 + 13'h0001;
	wire [15:0] inc_16 = {high, low} + 16'h0001;
	wire [7:0] inc_8 = low + 8'h01;
	wire low_full = (low == ALL_ONES_BYTE);

	always_comb begin
		low_next = low;
		high_next = high;
		overflow = 1'b0;
		if (tick) begin
			unique case (mode)
				MODE_13BIT: begin
					// upper three low bits are left alone
					low_next = {low[7:5], inc_13[4:0]};
					high_next = inc_13[12:5];
					overflow = (count_13 == ALL_ONES_13);
				end
				MODE_16BIT: begin
					{high_next, low_next} = inc_16;
					overflow = ({high, low} == ALL_ONES_16);
				end
				MODE_RELOAD: begin
					low_next = low_full ? high : inc_8;
					overflow = low_full;
				end
				MODE_SPLIT: begin
					low_next = inc_8;
					overflow = low_full;
				end
			endcase
		end
	end
endmodule

// *** dual_timer_counter_ctrl.sv ***
`timescale 1ns/100ps
module dual_timer_counter_ctrl (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// special function register port
	input timer_pkg::sfr_req_t sfr_req,
	output logic [7:0] rdata_reg,
	// core vectoring acknowledges, one-cycle pulses
	input timer_pkg::vector_ack_t vector_ack,
	// prescaled timer clock ticks, one-cycle pulses
	input wire logic timer_zero_clock_tick,
	input wire logic timer_one_clock_tick,
	// external pins
	input wire logic count_pin_zero,
	input wire logic count_pin_one,
	input wire logic ext_irq_zero_input,
	input wire logic ext_irq_one_input,
	// polarity configuration, 1 means active high
	input wire logic ext_irq_zero_polarity,
	input wire logic ext_irq_one_polarity,
	// interrupt request flags
	output logic timer_zero_overflow_flag,
	output logic timer_one_overflow_flag,
	output logic ext_irq_zero_flag,
	output logic ext_irq_one_flag,
	// overflow pulses for other peripherals
	output logic timer_zero_overflow_pulse_reg,
	output logic timer_one_overflow_pulse_reg
);
	import timer_pkg::*;

	function automatic logic byte_write(input sfr_req_t req, input logic [7:0] a);
		return req.wr_en && (req.addr == a);
	endfunction

	logic [7:0] timer_control_status_reg, timer_control_status_next;
	logic [7:0] timer_mode_config_reg;
	logic [7:0] timer_zero_count_low_reg, timer_zero_count_low_next;
	logic [7:0] timer_one_count_low_reg, timer_one_count_low_next;
	logic [7:0] timer_zero_count_high_reg, timer_zero_count_high_next;
	logic [7:0] timer_one_count_high_reg, timer_one_count_high_next;
	logic [7:0] read_mux;

	// pin synchronisation
	wire [PIN_TOTAL-1:0] raw_pins = {ext_irq_one_input, ext_irq_zero_input,
		count_pin_one, count_pin_zero};
	logic [PIN_TOTAL-1:0] pin_level, pin_prev;

	pin_sync #(.WIDTH(PIN_TOTAL)) u_pin_sync (
		.clk(clk),
		.rst(rst),
		.pin_in(raw_pins),
		.level(pin_level),
		.level_prev(pin_prev)
	);

	wire count_zero_fall = pin_prev[PIN_COUNT_ZERO] & ~pin_level[PIN_COUNT_ZERO];
	wire count_one_fall = pin_prev[PIN_COUNT_ONE] & ~pin_level[PIN_COUNT_ONE];
	wire irq_zero_active = ~(pin_level[PIN_IRQ_ZERO] ^ ext_irq_zero_polarity);
	wire irq_one_active = ~(pin_level[PIN_IRQ_ONE] ^ ext_irq_one_polarity);
	wire irq_zero_was = ~(pin_prev[PIN_IRQ_ZERO] ^ ext_irq_zero_polarity);
	wire irq_one_was = ~(pin_prev[PIN_IRQ_ONE] ^ ext_irq_one_polarity);

	// field decode
	wire [7:0] ctl = timer_control_status_reg;
	wire [7:0] md = timer_mode_config_reg;
	wire irq_zero_edge_mode = ctl[BIT_IRQ_ZERO_TYPE];
	wire irq_one_edge_mode = ctl[BIT_IRQ_ONE_TYPE];
	timer_mode_t zero_mode, one_mode;
	assign zero_mode = timer_mode_t'(md[BIT_ZERO_MODE_HI:BIT_ZERO_MODE_LO]);
	assign one_mode = timer_mode_t'(md[BIT_ONE_MODE_HI:BIT_ONE_MODE_LO]);
	wire zero_split = (zero_mode == MODE_SPLIT);
	wire one_inactive = (one_mode == MODE_SPLIT);

	// run control
	wire zero_enabled = ctl[BIT_ZERO_RUN]
		& (~md[BIT_ZERO_GATING] | irq_zero_active);
	wire one_enabled = ctl[BIT_ONE_RUN]
		& (~md[BIT_ONE_GATING] | irq_one_active);

	// count sources
	wire zero_source = md[BIT_ZERO_COUNT_SEL] ? count_zero_fall : timer_zero_clock_tick;
	wire one_source = md[BIT_ONE_COUNT_SEL] ? count_one_fall : timer_one_clock_tick;
	wire zero_tick = zero_enabled & zero_source;
	// split mode: timer one has no pin or run bit, only its mode stops it
	wire one_tick = ~one_inactive &
		(zero_split ? timer_one_clock_tick : (one_enabled & one_source));
	// split mode: high byte of timer zero runs on timer one run bit
	wire split_high_tick = zero_split & ctl[BIT_ONE_RUN] & timer_one_clock_tick;

	logic [7:0] zero_low_calc, zero_high_calc, one_low_calc, one_high_calc;
	logic zero_ovf, one_ovf;

	count_unit u_zero (
		.mode(zero_mode),
		.tick(zero_tick),
		.low(timer_zero_count_low_reg),
		.high(timer_zero_count_high_reg),
		.low_next(zero_low_calc),
		.high_next(zero_high_calc),
		.overflow(zero_ovf)
	);

	count_unit u_one (
		.mode(one_mode),
		.tick(one_tick),
		.low(timer_one_count_low_reg),
		.high(timer_one_count_high_reg),
		.low_next(one_low_calc),
		.high_next(one_high_calc),
		.overflow(one_ovf)
	);

	wire split_high_ovf = split_high_tick & (timer_zero_count_high_reg == ALL_ONES_BYTE);
	wire [7:0] split_high_inc = timer_zero_count_high_reg + 8'h01;

	// flag sources
	wire set_zero_ovf = zero_ovf;
	wire set_one_ovf = zero_split ? split_high_ovf : one_ovf;
	wire set_irq_zero = irq_zero_edge_mode ? (irq_zero_active & ~irq_zero_was)
		: irq_zero_active;
	wire set_irq_one = irq_one_edge_mode ? (irq_one_active & ~irq_one_was)
		: irq_one_active;

	// count register next values; a software write wins over counting
	assign timer_zero_count_low_next = byte_write(sfr_req, ADDR_ZERO_LOW) ? sfr_req.wdata
		: zero_low_calc;
	assign timer_one_count_low_next = byte_write(sfr_req, ADDR_ONE_LOW) ? sfr_req.wdata
		: one_low_calc;
	assign timer_zero_count_high_next = byte_write(sfr_req, ADDR_ZERO_HIGH) ? sfr_req.wdata
		: (split_high_tick ? split_high_inc : zero_high_calc);
	assign timer_one_count_high_next = byte_write(sfr_req, ADDR_ONE_HIGH) ? sfr_req.wdata
		: one_high_calc;

	// control register: software, then vector clears, then hardware sets
	always_comb begin
		timer_control_status_next = timer_control_status_reg;
		if (byte_write(sfr_req, ADDR_CONTROL_STATUS)) begin
			timer_control_status_next = sfr_req.wdata;
		end
		if (sfr_req.bit_wr_en) begin
			timer_control_status_next[sfr_req.bit_sel] = sfr_req.bit_val;
		end
		if (vector_ack.timer_one) begin
			timer_control_status_next[BIT_ONE_OVF] = 1'b0;
		end
		if (vector_ack.timer_zero) begin
			timer_control_status_next[BIT_ZERO_OVF] = 1'b0;
		end
		if (vector_ack.ext_irq_one && irq_one_edge_mode) begin
			timer_control_status_next[BIT_IRQ_ONE_FLAG] = 1'b0;
		end
		if (vector_ack.ext_irq_zero && irq_zero_edge_mode) begin
			timer_control_status_next[BIT_IRQ_ZERO_FLAG] = 1'b0;
		end
		// sets win over any clear in the same cycle
		if (set_one_ovf) begin
			timer_control_status_next[BIT_ONE_OVF] = 1'b1;
		end
		if (set_zero_ovf) begin
			timer_control_status_next[BIT_ZERO_OVF] = 1'b1;
		end
		if (set_irq_one) begin
			timer_control_status_next[BIT_IRQ_ONE_FLAG] = 1'b1;
		end
		if (set_irq_zero) begin
			timer_control_status_next[BIT_IRQ_ZERO_FLAG] = 1'b1;
		end
	end

	// read selection
	always_comb begin
		unique case (sfr_req.addr)
			ADDR_CONTROL_STATUS: read_mux = timer_control_status_reg;
			ADDR_MODE_CONFIG: read_mux = timer_mode_config_reg;
			ADDR_ZERO_LOW: read_mux = timer_zero_count_low_reg;
			ADDR_ONE_LOW: read_mux = timer_one_count_low_reg;
			ADDR_ZERO_HIGH: read_mux = timer_zero_count_high_reg;
			ADDR_ONE_HIGH: read_mux = timer_one_count_high_reg;
			default: read_mux = UNMAPPED_BYTE;
		endcase
	end

	// run bits only gate ticks; counts are never cleared by them
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			timer_control_status_reg <= RESET_BYTE;
			timer_mode_config_reg <= RESET_BYTE;
			timer_zero_count_low_reg <= RESET_BYTE;
			timer_one_count_low_reg <= RESET_BYTE;
			timer_zero_count_high_reg <= RESET_BYTE;
			timer_one_count_high_reg <= RESET_BYTE;
		end else begin
			timer_control_status_reg <= timer_control_status_next;
			if (byte_write(sfr_req, ADDR_MODE_CONFIG)) begin
				timer_mode_config_reg <= sfr_req.wdata;
			end
			timer_zero_count_low_reg <= timer_zero_count_low_next;
			timer_one_count_low_reg <= timer_one_count_low_next;
			timer_zero_count_high_reg <= timer_zero_count_high_next;
			timer_one_count_high_reg <= timer_one_count_high_next;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= RESET_BYTE;
			timer_zero_overflow_pulse_reg <= 1'b0;
			timer_one_overflow_pulse_reg <= 1'b0;
		end else begin
			if (sfr_req.rd_en) begin
				rdata_reg <= read_mux;
			end
			timer_zero_overflow_pulse_reg <= zero_ovf;
			timer_one_overflow_pulse_reg <= one_ovf;
		end
	end

	assign timer_one_overflow_flag = timer_control_status_reg[BIT_ONE_OVF];
	assign timer_zero_overflow_flag = timer_control_status_reg[BIT_ZERO_OVF];
	assign ext_irq_one_flag = timer_control_status_reg[BIT_IRQ_ONE_FLAG];
	assign ext_irq_zero_flag = timer_control_status_reg[BIT_IRQ_ZERO_FLAG];
endmodule

// *** timer_ctrl_monitor.sv ***
`timescale 1ns/100ps
module timer_ctrl_monitor import timer_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input timer_pkg::sfr_req_t sfr_req,
	input wire logic [7:0] rdata_reg,
	input timer_pkg::vector_ack_t vector_ack,
	// flags and pulses
	input wire logic timer_zero_overflow_flag,
	input wire logic timer_one_overflow_flag,
	input wire logic ext_irq_zero_flag,
	input wire logic ext_irq_one_flag,
	input wire logic timer_zero_overflow_pulse_reg,
	input wire logic timer_one_overflow_pulse_reg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic [7:0] mode_shadow;
	logic wr_mode;
	assign wr_mode = sfr_req.wr_en && sfr_req.addr == ADDR_MODE_CONFIG;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) mode_shadow <= 8'h00;
		else if (wr_mode) mode_shadow <= sfr_req.wdata;
	end
	zero_ovf_pulse_a: assert property ($rose(timer_zero_overflow_flag) && !$past(sfr_req.wr_en)
		&& !$past(sfr_req.bit_wr_en) |-> timer_zero_overflow_pulse_reg) else $error("no overflow pulse");
	zero_ack_clear_a: assert property (vector_ack.timer_zero && !sfr_req.wr_en && !sfr_req.bit_wr_en
		|=> !timer_zero_overflow_flag || timer_zero_overflow_pulse_reg) else $error("ack kept flag");
	unmapped_zero_a: assert property (sfr_req.rd_en && sfr_req.addr > ADDR_ONE_HIGH
		|=> rdata_reg == 8'h00) else $error("unmapped read not zero");
	rdata_hold_a: assert property (!sfr_req.rd_en |=> $stable(rdata_reg)) else $error("rdata moved");
	status_read_a: assert property (sfr_req.rd_en && sfr_req.addr == ADDR_CONTROL_STATUS |=>
		rdata_reg[7] == $past(timer_one_overflow_flag) && rdata_reg[5] == $past(timer_zero_overflow_flag)
		&& rdata_reg[3] == $past(ext_irq_one_flag) && rdata_reg[1] == $past(ext_irq_zero_flag))
		else $error("status read mismatch");
	bit_clear_a: assert property (sfr_req.bit_wr_en && sfr_req.bit_sel == 3'd5 && !sfr_req.bit_val
		|=> !timer_zero_overflow_flag || timer_zero_overflow_pulse_reg) else $error("bit clear lost");
	mode_readback_a: assert property (sfr_req.rd_en && sfr_req.addr == ADDR_MODE_CONFIG
		|=> rdata_reg == $past(mode_shadow)) else $error("mode readback wrong");
	reset_quiet_a: assert property ($fell(rst) |-> rdata_reg == 8'h00 && !timer_zero_overflow_flag
		&& !timer_one_overflow_flag && !ext_irq_zero_flag && !ext_irq_one_flag) else $error("reset dirty");
	cover property (timer_zero_overflow_pulse_reg);
	cover property (timer_one_overflow_flag);
	cover property (ext_irq_one_flag);
	cover property (timer_one_overflow_pulse_reg);
endmodule
bind dual_timer_counter_ctrl timer_ctrl_monitor u_mon (.clk(clk), .rst(rst), .sfr_req(sfr_req),
	.rdata_reg(rdata_reg), .vector_ack(vector_ack), .timer_zero_overflow_flag(timer_zero_overflow_flag),
	.timer_one_overflow_flag(timer_one_overflow_flag), .ext_irq_zero_flag(ext_irq_zero_flag),
	.ext_irq_one_flag(ext_irq_one_flag), .timer_zero_overflow_pulse_reg(timer_zero_overflow_pulse_reg),
	.timer_one_overflow_pulse_reg(timer_one_overflow_pulse_reg));

// *** core_model.sv ***
`timescale 1ns/100ps
module core_model import timer_pkg::*; (
	// clock and read data
	input wire logic clk,
	input wire logic [7:0] rdata,
	// requests and vectoring
	output sfr_req_t req,
	output vector_ack_t ack
);
	initial begin
		req = '0;
		ack = '0;
	end
	// hold over one rising edge, then scramble released lines
	task automatic go(input sfr_req_t r);
		sfr_req_t idle;
		idle = '0;
		idle.addr = ~r.addr;
		idle.wdata = ~r.wdata;
		@(negedge clk) req = r;
		@(negedge clk) req = idle;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_req_t r;
		r = '0;
		r.wr_en = 1'b1;
		r.addr = a;
		r.wdata = d;
		go(r);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		sfr_req_t r;
		r = '0;
		r.rd_en = 1'b1;
		r.addr = a;
		go(r);
		d = rdata;
	endtask
	task automatic bw(input logic [2:0] b, input logic v);
		sfr_req_t r;
		r = '0;
		r.bit_wr_en = 1'b1;
		r.addr = ADDR_CONTROL_STATUS;
		r.bit_sel = b;
		r.bit_val = v;
		go(r);
	endtask
	task automatic pulse(input vector_ack_t v);
		@(negedge clk) ack = v;
		@(negedge clk) ack = '0;
	endtask
endmodule

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
	import timer_pkg::*;
	logic clk, rst, t0, t1, p0, p1, i0, i1, pol0, pol1;
	logic [7:0] rdata;
	sfr_req_t req;
	vector_ack_t ack;
	int fail_count = 0;
	int num_checks = 0;
	logic [7:0] adr [5] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h90};
	dual_timer_counter_ctrl DUT (.clk(clk), .rst(rst), .sfr_req(req), .rdata_reg(rdata),
		.vector_ack(ack), .timer_zero_clock_tick(t0), .timer_one_clock_tick(t1),
		.count_pin_zero(p0), .count_pin_one(p1), .ext_irq_zero_input(i0), .ext_irq_one_input(i1),
		.ext_irq_zero_polarity(pol0), .ext_irq_one_polarity(pol1),
		.timer_zero_overflow_flag(), .timer_one_overflow_flag(), .ext_irq_zero_flag(),
		.ext_irq_one_flag(), .timer_zero_overflow_pulse_reg(), .timer_one_overflow_pulse_reg());
	core_model u_core (.clk(clk), .rdata(rdata), .req(req), .ack(ack));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] t=%0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		u_core.rd(a, d);
		chk(d, e);
	endtask
	task automatic tk(input logic [1:0] m, input int n);
		@(negedge clk) {t1, t0} = m;
		repeat (n) @(negedge clk);
		{t1, t0} = 2'b00;
	endtask
	task automatic wt();
		repeat (4) @(negedge clk);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#100000;
		fail_count++;
		print_verdict;
	end
	initial begin
		{rst, t0, t1, p0, p1, i0, i1, pol0, pol1} = 9'h133;
		repeat (12) @(negedge clk);
		rst = 1'b0;
		foreach (adr[k]) rc(adr[k], 8'h00);
		u_core.wr(8'h89, 8'h5a);
		u_core.wr(8'h8a, 8'h55);
		u_core.wr(8'h8b, 8'haa);
		rc(8'h89, 8'h5a);
		rc(8'h8a, 8'h55);
		rc(8'h8b, 8'haa);
		u_core.bw(3'd6, 1'b1);
		rc(8'h88, 8'h40);
		u_core.bw(3'd6, 1'b0);
		$display("test registers done");
		u_core.wr(8'h89, 8'h01);
		u_core.wr(8'h8a, 8'hfe);
		u_core.wr(8'h8c, 8'hff);
		u_core.bw(3'd4, 1'b1);
		rc(8'h8a, 8'hfe);
		tk(2'b01, 2);
		rc(8'h88, 8'h30);
		rc(8'h8a, 8'h00);
		u_core.pulse(4'b0100);
		rc(8'h88, 8'h10);
		u_core.wr(8'h89, 8'h00);
		u_core.wr(8'h8a, 8'hff);
		u_core.wr(8'h8c, 8'hff);
		tk(2'b01, 1);
		rc(8'h8a, 8'he0);
		rc(8'h8c, 8'h00);
		u_core.bw(3'd5, 1'b0);
		rc(8'h88, 8'h10);
		u_core.wr(8'h89, 8'h02);
		u_core.wr(8'h8a, 8'hff);
		u_core.wr(8'h8c, 8'h33);
		tk(2'b01, 1);
		rc(8'h8a, 8'h33);
		rc(8'h8c, 8'h33);
		rc(8'h88, 8'h30);
		u_core.bw(3'd5, 1'b0);
		$display("test modes done");
		u_core.wr(8'h89, 8'h09);
		u_core.wr(8'h8a, 8'h10);
		tk(2'b01, 1);
		rc(8'h8a, 8'h10);
		i0 = 1'b1;
		wt();
		tk(2'b01, 1);
		rc(8'h8a, 8'h11);
		u_core.pulse(4'b0001);
		rc(8'h88, 8'h12);
		i0 = 1'b0;
		wt();
		u_core.bw(3'd1, 1'b0);
		rc(8'h88, 8'h10);
		u_core.bw(3'd0, 1'b1);
		i0 = 1'b1;
		wt();
		rc(8'h88, 8'h13);
		u_core.pulse(4'b0001);
		rc(8'h88, 8'h11);
		i0 = 1'b0;
		u_core.wr(8'h89, 8'h05);
		u_core.wr(8'h8a, 8'h00);
		p0 = 1'b0;
		repeat (6) @(negedge clk);
		p0 = 1'b1;
		tk(2'b01, 6);
		rc(8'h8a, 8'h01);
		$display("test gate and pins done");
		u_core.bw(3'd4, 1'b0);
		u_core.wr(8'h89, 8'h30);
		u_core.bw(3'd6, 1'b1);
		u_core.wr(8'h8b, 8'hff);
		u_core.wr(8'h8d, 8'hff);
		tk(2'b10, 1);
		rc(8'h8b, 8'hff);
		u_core.wr(8'h89, 8'h10);
		tk(2'b10, 1);
		rc(8'h8b, 8'h00);
		rc(8'h88, 8'hc1);
		u_core.pulse(4'b1000);
		rc(8'h88, 8'h41);
		u_core.wr(8'h89, 8'h13);
		u_core.wr(8'h8a, 8'hff);
		u_core.wr(8'h8c, 8'hff);
		u_core.bw(3'd4, 1'b1);
		tk(2'b10, 1);
		rc(8'h88, 8'hd1);
		tk(2'b01, 1);
		rc(8'h88, 8'hf1);
		rc(8'h8c, 8'h00);
		$display("test timer one and split done");
		pol1 = 1'b0;
		wt();
		rc(8'h88, 8'hf9);
		i1 = 1'b1;
		wt();
		u_core.bw(3'd3, 1'b0);
		u_core.bw(3'd2, 1'b1);
		i1 = 1'b0;
		wt();
		rc(8'h88, 8'hfd);
		u_core.pulse(4'b0010);
		rc(8'h88, 8'hf5);
		// input one back to inactive so level mode stays quiet after reset
		pol1 = 1'b1;
		rst = 1'b1;
		wt();
		rst = 1'b0;
		rc(8'h88, 8'h00);
		$display("test interrupts and reset done");
		print_verdict;
	end
endmodule
